// *** include/polsel_pkg.sv ***
// Purpose: constants and carrier types for the switch input polarity stage
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes:   type bit set means contact closed is valid, clear means open
package polsel_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_MAIN_TYPE = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_CAR_TYPE  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_MAIN_VAL  = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_CAR_VAL   = 4'hC;
  // main board reset types: slowdown ports 3,4,7,8 and thermal 21 are OFF
  localparam logic [31:0] MAIN_TYPE_RST = 32'hFFDF_FE67;
  // car board field positions
  localparam int unsigned CAR_DOOR_CLOSE2 = 4;
  localparam int unsigned CAR_DOOR_OPEN2  = 5;
  localparam int unsigned CAR_DOOR_CLOSE1 = 6;
  localparam int unsigned CAR_DOOR_OPEN1  = 7;
  localparam int unsigned CAR_FULL_LOAD   = 13;
  localparam int unsigned CAR_LIGHT_LOAD  = 14;
  localparam int unsigned CAR_OVERLOAD    = 15;
  localparam int unsigned CAR_EDGE2       = 17;
  localparam int unsigned CAR_EDGE1       = 18;
  // car reset types: load inputs ON, door limits and edges OFF
  localparam logic [31:0] CAR_TYPE_RST = 32'h0000_E000;
  // bits that exist in the car word
  localparam logic [31:0] CAR_TYPE_MASK = 32'h0006_E0F0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [31:0] main_raw;
    logic [31:0] car_raw;
  } contact_t;
endpackage : polsel_pkg

// *** rtl/switch_input_polarity_select.sv ***
// Purpose: turn raw switch contact states into valid levels by type bits
// Assumes: contact input high means closed; inputs asynchronous to mclk_i
// Notes:   differential pairs 29..31 arrive as one resolved contact each

module switch_input_polarity_select (
  input  wire logic                         mclk_i,
  input  wire logic                         nrst_i,
  input  wire polsel_pkg::contact_t         contact_i,
  input  wire logic [polsel_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [polsel_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic [31:0]                       main_valid_o,
  output logic [31:0]                       car_valid_o
);
  import polsel_pkg::*;

  logic [31:0]       main_type_r;
  logic [31:0]       car_type_r;
  contact_t          sync1_r;
  contact_t          sync2_r;
  logic              aw_held_r;
  logic              w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              wr_go;
  logic [31:0]       main_type_nxt;
  logic [31:0]       car_type_nxt;

  // two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= contact_i;
      sync2_r <= sync1_r;
    end
  end

  // polarity: valid = closed when type ON, open when type OFF
  // xnor form keeps the per-bit path one gate deep
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      main_valid_o <= '0;
      car_valid_o  <= '0;
    end
    else
    begin
      main_valid_o <= ~(sync2_r.main_raw ^ main_type_r);
      car_valid_o  <= ~(sync2_r.car_raw ^ car_type_r)
                      & CAR_TYPE_MASK;
    end
  end

  // write address and data may arrive in either order; hold each
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      else if (wr_go)
        aw_held_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      else if (wr_go)
        w_held_r <= 1'b0;
    end
  end

  // one write in flight: no new accept until the response is taken
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready)
                       && !s_axi_bvalid && !wr_go;
      s_axi_wready  <= !w_held_r && !(s_axi_wvalid && s_axi_wready)
                       && !s_axi_bvalid && !wr_go;
    end
  end

  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

  // byte-lane merge of the write data into the type words
  always_comb
  begin
    main_type_nxt = main_type_r;
    car_type_nxt  = car_type_r;
    for (int i = 0; i < 4; i++)
    begin
      if (wstrb_r[i])
      begin
        main_type_nxt[i*8 +: 8] = wdata_r[i*8 +: 8];
        car_type_nxt[i*8 +: 8]  = wdata_r[i*8 +: 8];
      end
    end
  end

  // type words; pair bits 29..31 each cover both legs of a pair
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      main_type_r <= MAIN_TYPE_RST;
      car_type_r  <= CAR_TYPE_RST;
    end
    else if (wr_go)
    begin
      if (awaddr_r == OFS_MAIN_TYPE)
        main_type_r <= main_type_nxt;
      else if (awaddr_r == OFS_CAR_TYPE)
        car_type_r <= car_type_nxt & CAR_TYPE_MASK;
    end
  end

  // write response; unmapped or read-only offsets answer SLVERR
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (awaddr_r == OFS_MAIN_TYPE || awaddr_r == OFS_CAR_TYPE)
                      ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read channel: accept, then answer the next cycle
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case (s_axi_araddr)
          OFS_MAIN_TYPE: s_axi_rdata <= main_type_r;
          OFS_CAR_TYPE:  s_axi_rdata <= car_type_r;
          OFS_MAIN_VAL:  s_axi_rdata <= main_valid_o;
          OFS_CAR_VAL:   s_axi_rdata <= car_valid_o;
          default:
          begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  // first edge after release still shows the reset value, so skip it
  property p_main_pol;
    @(posedge mclk_i) disable iff (!nrst_i)
    $past(nrst_i) |->
      main_valid_o == ~($past(sync2_r.main_raw) ^ $past(main_type_r));
  endproperty
  a_main_pol: assert property (p_main_pol)
    else $error("main polarity wrong");

  property p_closed_on;
    @(posedge mclk_i) disable iff (!nrst_i)
    (sync2_r.car_raw[CAR_OVERLOAD] && car_type_r[CAR_OVERLOAD])
      |=> car_valid_o[CAR_OVERLOAD];
  endproperty
  a_closed_on: assert property (p_closed_on)
    else $error("closed ON contact not valid");

  property p_open_off;
    @(posedge mclk_i) disable iff (!nrst_i)
    (!sync2_r.car_raw[CAR_EDGE1] && !car_type_r[CAR_EDGE1])
      |=> car_valid_o[CAR_EDGE1];
  endproperty
  a_open_off: assert property (p_open_off)
    else $error("open OFF contact not valid");

  property p_sync;
    @(posedge mclk_i) disable iff (!nrst_i)
    sync2_r == $past(contact_i, 2);
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync depth not two");

  property p_main_wr;
    @(posedge mclk_i) disable iff (!nrst_i)
    (wr_go && awaddr_r == OFS_MAIN_TYPE && wstrb_r == 4'hF)
      |=> main_type_r == $past(wdata_r);
  endproperty
  a_main_wr: assert property (p_main_wr)
    else $error("main type write lost");

  property p_car_mask;
    @(posedge mclk_i) disable iff (!nrst_i)
    (car_type_r & ~CAR_TYPE_MASK) == 32'h0000_0000;
  endproperty
  a_car_mask: assert property (p_car_mask)
    else $error("car type outside fields");

  property p_main_hold;
    @(posedge mclk_i) disable iff (!nrst_i)
    !(wr_go && awaddr_r == OFS_MAIN_TYPE) |=> $stable(main_type_r);
  endproperty
  a_main_hold: assert property (p_main_hold)
    else $error("main type changed without write");

  property p_bresp;
    @(posedge mclk_i) disable iff (!nrst_i)
    wr_go |=> s_axi_bvalid
      && ((s_axi_bresp == RESP_OKAY) == ($past(awaddr_r) == OFS_MAIN_TYPE
      || $past(awaddr_r) == OFS_CAR_TYPE));
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write response missing or wrong");

  property p_slow_off;
    @(posedge mclk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> !main_type_r[3] && !main_type_r[4]
      && !main_type_r[7] && !main_type_r[8];
  endproperty
  a_slow_off: assert property (p_slow_off)
    else $error("slowdown type not OFF after reset");

  property p_pair_on;
    @(posedge mclk_i) disable iff (!nrst_i)
    $rose(nrst_i) |-> main_type_r[31:29] == 3'h7;
  endproperty
  a_pair_on: assert property (p_pair_on)
    else $error("pair type not ON after reset");

  c_write: cover property (@(posedge mclk_i) wr_go);
  c_read: cover property (@(posedge mclk_i) s_axi_rvalid && s_axi_rready);
  c_off_valid: cover property (@(posedge mclk_i)
    main_valid_o[3] && !main_type_r[3]);
endmodule : switch_input_polarity_select

// *** tb/switch_field.sv ***
// Purpose: shaft, car and contactor switches seen by the polarity stage
// Assumes: 1 = contact closed; a contact moves lag_i+1 edges after the edge that takes a request
// Notes:   contact bounce is not modelled
module switch_field (
  input  wire logic                 mclk_i,
  input  wire logic [3:0]           lag_i,
  input  wire polsel_pkg::contact_t want_i,
  output polsel_pkg::contact_t      contact_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import polsel_pkg::*;
  contact_t   pend_r = '0;
  logic [3:0] cnt_r  = 4'h0;
  initial contact_o = '0;
  // slow switches hold their old state for lag_i edges after taking a request
  always @(posedge mclk_i)
  begin
    if (want_i != pend_r)
    begin
      pend_r <= want_i;
      cnt_r  <= lag_i;
    end
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
    else
      contact_o <= pend_r;
  end
endmodule : switch_field

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the switch input polarity stage
// Assumes: register answers arrive in request order
// Notes:   expected values come from the bench's own type copies
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import polsel_pkg::*;
  logic        mclk_i = 0, nrst_i = 0, awvalid = 0, wvalid = 0;
  logic        bready = 0, arvalid = 0, rready = 0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, lag = 4'h0;
  logic [31:0] wdata = 32'h0, mt, ct, cmask = 32'h0, seed = 32'd74113;
  logic [31:0] rdata, mval, cval;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  contact_t    want = '0, old, cont;
  logic [33:0] rd_q[$];
  logic [1:0]  wr_q[$];
  int          failures = 0, check_count = 0;
  int          pos[9] = '{7, 6, 5, 4, 18, 17, 15, 13, 14};

  initial forever #4 mclk_i = ~mclk_i;

  switch_field sw (.mclk_i(mclk_i), .lag_i(lag), .want_i(want),
    .contact_o(cont));
  switch_input_polarity_select dut (.mclk_i(mclk_i), .nrst_i(nrst_i),
    .contact_i(cont), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .main_valid_o(mval), .car_valid_o(cval));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic bad(input string m);
    failures++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : bad

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // valid level is closed-when-ON, open-when-OFF, per bit
  task automatic cmp_val(input contact_t c);
    check_count++;
    if (mval !== ~(c.main_raw ^ mt) || cval !== (~(c.car_raw ^ ct) & cmask))
      bad("valid levels");
  endtask : cmp_val

  // read answer against the oldest read note
  task automatic cmp_rd();
    check_count++;
    if (rd_q.size() == 0 || {rresp, rdata} !== rd_q.pop_front())
      bad("read answer");
  endtask : cmp_rd

  // write response against the oldest write note
  task automatic cmp_wr();
    check_count++;
    if (wr_q.size() == 0 || bresp !== wr_q.pop_front())
      bad("write answer");
  endtask : cmp_wr

  // monitor: each bus answer is matched against the oldest note
  always @(posedge mclk_i)
  begin
    if (rvalid && rready)
      cmp_rd();
    if (bvalid && bready)
      cmp_wr();
  end

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] st);
    logic [31:0] m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    if (a == 4'h0) mt = (mt & ~m) | (d & m);
    if (a == 4'h4) ct = ((ct & ~m) | (d & m)) & cmask;
    wr_q.push_back((a == 4'h0 || a == 4'h4) ? RESP_OKAY : RESP_SLVERR);
    @(posedge mclk_i);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= st;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // only the watchdog ends a wait that never gets its answer
    do
    begin
      @(posedge mclk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    logic [31:0] e;
    case (a)
      4'h0: e = mt;
      4'h4: e = ct;
      4'h8: e = ~(want.main_raw ^ mt);
      4'hC: e = ~(want.car_raw ^ ct) & cmask;
      default: e = 32'h0;
    endcase
    rd_q.push_back({(a[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR, e});
    @(posedge mclk_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
  endtask : rd

  // cut a hang short well past the expected run length
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    failures++;
    tally_and_finish();
  end

  initial
  begin
    foreach (pos[i]) cmask[pos[i]] = 1'b1;
    mt = 32'hFFFF_FFFF & ~((32'h1 << 3) | (32'h1 << 4) | (32'h1 << 7));
    mt = mt & ~((32'h1 << 8) | (32'h1 << 21));
    ct = (32'h1 << 13) | (32'h1 << 14) | (32'h1 << 15);
    repeat (5) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rd(4'h0);
    rd(4'h4);
    repeat (8) @(posedge mclk_i);
    cmp_val(want);
    wr(4'h4, 32'hFFFF_FFFF, 4'hF);
    rd(4'h4);
    for (int i = 0; i < 8; i++)
    begin
      old = want;
      seed = lfsr(seed);
      want.main_raw <= seed;
      lag <= seed[3:0];
      seed = lfsr(seed);
      want.car_raw <= seed;
      repeat (2) @(posedge mclk_i);
      cmp_val(old);
      seed = lfsr(seed);
      wr(4'h0, seed, seed[7:4]);
      seed = lfsr(seed);
      wr(4'h4, seed, 4'hF);
      repeat (24) @(posedge mclk_i);
      cmp_val(want);
      rd(4'h8);
      rd(4'hC);
    end
    // limits wired open in normal state get type OFF
    wr(4'h0, mt & ~32'h0000_0060, 4'hF);
    wr(4'h8, 32'h0, 4'hF);
    rd(4'h2);
    rd(4'h0);
    repeat (8) @(posedge mclk_i);
    cmp_val(want);
    tally_and_finish();
  end
endmodule : tb_top
